// File: common/csfwd_pkg.sv
// Package: constants and types of the CSI-2 video forwarding control block
package csfwd_pkg;

	// ****************************************************************
	// Register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [7:0] IDX_PORT_DISABLE = 8'h20;
	localparam logic [7:0] IDX_MODE_CONTROL = 8'h21;
	localparam logic [7:0] IDX_STATUS       = 8'h22;
	localparam logic [7:0] IDX_IRQ_STATUS   = 8'h30;
	localparam logic [7:0] IDX_IRQ_MASK     = 8'h31;

	// ****************************************************************
	// Reset values and field positions
	// ****************************************************************
	localparam logic [7:0] RST_PORT_DISABLE = 8'hf0;
	localparam logic [7:0] RST_MODE_CONTROL = 8'h03;
	localparam logic [1:0] RST_IRQ          = 2'h0;
	localparam int         POS_DIS_LO       = 4;
	localparam int         POS_DIS_HI       = 7;
	localparam int         POS_WHEN_READY   = 6;
	localparam int         POS_MODE_LO      = 2;
	localparam int         POS_MODE_HI      = 3;
	localparam int         POS_BEST_EFFORT  = 0;
	localparam int         POS_SYNC_ACTIVE  = 0;
	localparam int         POS_SYNC_FAIL    = 2;
	localparam logic [7:0] MODE_WR_MASK     = 8'h4d;
	localparam logic [7:0] DIS_WR_MASK      = 8'hf0;

	// Interrupt status bits: failure, synchronisation gained
	localparam int IRQ_FAIL = 0;
	localparam int IRQ_GAIN = 1;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ          = 40_000_000;
	localparam int SYNC_TIMEOUT_US = 100;
	localparam int SYNC_TO_CYC     = SYNC_TIMEOUT_US * (CLK_HZ / 1_000_000);
	localparam logic [11:0] SYNC_TO_LAST = 12'(SYNC_TO_CYC - 1);

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		SYNC_OFF    = 2'h0,
		SYNC_BASIC  = 2'h1,
		SYNC_INTERL = 2'h2,
		SYNC_CONCAT = 2'h3
	} csfwd_sync_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_SEND = 2'h2
	} csfwd_state_e;

	// One beat of a CSI-2 packet from a receive port or to the output
	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  port;
		logic        sop;
		logic        eop;
		logic        long_pkt;
		logic        frame_end;
	} csfwd_beat_s;

	localparam int NPORT = 4;

endpackage

// File: logic/csfwd_engine.sv
// CSI-2 video forwarding engine with Avalon-MM register slave
`timescale 1ns/1ps

module csfwd_engine
	import csfwd_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Receive ports
	input  wire logic [3:0]  rx_valid_i,
	input  csfwd_beat_s      rx_beat_i [NPORT],
	output logic [3:0]       rx_ready_o,
	// CSI-2 output stream
	output logic             tx_valid_o,
	output csfwd_beat_s      tx_beat_o,
	input  wire logic        tx_ready_i,
	// Interrupt
	output logic             irq_o
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [7:0]   port_dis_r;
	logic [7:0]   mode_r;
	logic [1:0]   irq_sts_r;
	logic [1:0]   irq_mask_r;
	logic         ack_r;
	logic [31:0]  rdata_r;
	logic         sync_active_r;
	logic         frame_ok_r;
	logic         sync_fail_r;
	logic [3:0]   line_mask_r;
	logic [3:0]   fe_mask_r;
	logic [3:0]   sp_mask_r;
	logic [11:0]  to_cnt_r;
	logic [1:0]   cur_r;
	logic [1:0]   last_r;
	csfwd_state_e state_r;
	logic         tx_valid_r;
	csfwd_beat_s  tx_beat_r;

	logic [3:0]   en_mask;
	logic         sync_on;
	logic         best_on;
	logic         as_eff;
	logic [3:0]   valid_en;
	logic         all_ready;
	logic         short_ready;
	logic [3:0]   elig;
	logic         load_ok;
	logic         cur_take;
	logic         cur_fwd;
	logic         pkt_done;
	logic         to_hit;
	logic [3:0]   line_nxt;
	logic [3:0]   fe_nxt;
	logic [3:0]   sp_nxt;
	logic         line_round;
	logic         frame_round;
	logic         sp_round;
	logic         fail_evt;
	logic         gain_evt;
	logic         wr_acc;
	logic         rd_acc;
	logic [7:0]   status_view;

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	// Round robin: first requester after the last served port
	function automatic logic [1:0] rr_pick(input logic [3:0] req, input logic [1:0] last);
		logic [1:0] idx;
		logic [1:0] pick;
		logic       found;
		pick  = last;
		found = 1'b0;
		for (int i = 1; i <= NPORT; i++) begin
			idx = 2'(last + 2'(i));
			if (req[idx] && !found) begin
				pick  = idx;
				found = 1'b1;
			end
		end
		return pick;
	endfunction

	// Register index decode, used for read and write
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] idx);
		return (addr[1:0] == 2'h0) && (addr[7:2] == idx[5:0]);
	endfunction

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	// Sync mode wins if software breaks exclusivity, so lines never lose order
	assign en_mask   = ~port_dis_r[POS_DIS_HI:POS_DIS_LO];
	assign sync_on   = csfwd_sync_e'(mode_r[POS_MODE_HI:POS_MODE_LO]) != SYNC_OFF;
	assign best_on   = mode_r[POS_BEST_EFFORT] && !sync_on;
	assign as_eff    = mode_r[POS_WHEN_READY] &&
	                   csfwd_sync_e'(mode_r[POS_MODE_HI:POS_MODE_LO]) != SYNC_CONCAT;
	assign valid_en  = rx_valid_i & en_mask;
	// Ports already served in this round count as present, else the round deadlocks
	assign all_ready   = ((valid_en | line_mask_r | ~en_mask) == 4'hf) && (en_mask != 4'h0);
	assign short_ready = ((valid_en | sp_mask_r | ~en_mask) == 4'hf) && (en_mask != 4'h0);

	// Eligibility of each port's head packet
	genvar gp;
	generate
		for (gp = 0; gp < NPORT; gp++) begin : g_elig
			assign elig[gp] = valid_en[gp] && (best_on ||
				(sync_on && (rx_beat_i[gp].long_pkt ?
					(!line_mask_r[gp] && (all_ready || as_eff)) :
					(!sp_mask_r[gp] && short_ready))));
		end
	endgenerate

	// ****************************************************************
	// Stream handshake
	// ****************************************************************
	// Output register takes a beat when empty or being drained
	assign load_ok  = !tx_valid_r || tx_ready_i;
	assign cur_take = (state_r == ST_SEND) && rx_valid_i[cur_r] && rx_ready_o[cur_r];
	assign cur_fwd  = cur_take && en_mask[cur_r];
	assign pkt_done = cur_take && rx_beat_i[cur_r].eop;

	// Disabled ports are drained and dropped so their receivers never stall
	generate
		for (gp = 0; gp < NPORT; gp++) begin : g_ready
			assign rx_ready_o[gp] = !en_mask[gp] ||
				((state_r == ST_SEND) && (cur_r == 2'(gp)) && load_ok);
		end
	endgenerate

	assign tx_valid_o = tx_valid_r;
	assign tx_beat_o  = tx_beat_r;

	// Arbiter state machine, locked to one port until end of packet
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= ST_IDLE;
			cur_r   <= 2'h0;
			last_r  <= 2'h3;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (elig != 4'h0) begin
						cur_r   <= rr_pick(elig, last_r);
						state_r <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (pkt_done) begin
						last_r  <= cur_r;
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Output beat register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_valid_r <= 1'b0;
			tx_beat_r  <= '0;
		end else if (load_ok) begin
			tx_valid_r <= cur_fwd;
			if (cur_fwd) begin
				tx_beat_r      <= rx_beat_i[cur_r];
				tx_beat_r.port <= cur_r;
			end
		end
	end

	// ****************************************************************
	// Synchronisation tracking
	// ****************************************************************
	// A round is complete once every enabled port has sent its line
	assign line_nxt    = line_mask_r | ((pkt_done && cur_fwd && rx_beat_i[cur_r].long_pkt) ?
	                     (4'h1 << cur_r) : 4'h0);
	assign fe_nxt      = fe_mask_r | ((pkt_done && cur_fwd && rx_beat_i[cur_r].frame_end) ?
	                     (4'h1 << cur_r) : 4'h0);
	assign sp_nxt      = sp_mask_r | ((pkt_done && cur_fwd && !rx_beat_i[cur_r].long_pkt) ?
	                     (4'h1 << cur_r) : 4'h0);
	assign sp_round    = (en_mask != 4'h0) && ((sp_nxt & en_mask) == en_mask);
	assign line_round  = sync_on && (en_mask != 4'h0) && ((line_nxt & en_mask) == en_mask);
	assign frame_round = sync_on && (en_mask != 4'h0) && ((fe_nxt & en_mask) == en_mask);
	assign to_hit      = sync_on && (to_cnt_r == SYNC_TO_LAST);
	assign fail_evt    = to_hit && frame_ok_r;
	assign gain_evt    = line_round && !sync_active_r;

	// Per-round masks, restarted when sync mode is left
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			line_mask_r <= 4'h0;
			fe_mask_r   <= 4'h0;
		end else if (!sync_on || to_hit) begin
			line_mask_r <= 4'h0;
			fe_mask_r   <= 4'h0;
		end else begin
			line_mask_r <= line_round ? 4'h0 : line_nxt;
			fe_mask_r   <= frame_round ? 4'h0 : fe_nxt;
		end
	end

	// Short packets of a round, one per enabled port before the next round opens
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sp_mask_r <= 4'h0;
		end else if (!sync_on || to_hit || sp_round) begin
			sp_mask_r <= 4'h0;
		end else begin
			sp_mask_r <= sp_nxt;
		end
	end

	// Timeout: a port has a line waiting while another enabled port stays silent
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			to_cnt_r <= 12'h000;
		end else if (!sync_on || all_ready || short_ready || valid_en == 4'h0 || to_hit) begin
			to_cnt_r <= 12'h000;
		end else begin
			to_cnt_r <= to_cnt_r + 12'h001;
		end
	end

	// Synchronized flag and first-good-frame memory
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync_active_r <= 1'b0;
			frame_ok_r    <= 1'b0;
		end else if (!sync_on || to_hit) begin
			sync_active_r <= 1'b0;
			frame_ok_r    <= 1'b0;
		end else begin
			if (line_round)
				sync_active_r <= 1'b1;
			if (frame_round && sync_active_r)
				frame_ok_r <= 1'b1;
		end
	end

	// Sticky failure flag; a new failure beats the read clear
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync_fail_r <= 1'b0;
		end else if (fail_evt) begin
			sync_fail_r <= 1'b1;
		end else if (rd_acc && hit(avs_address_i, IDX_STATUS)) begin
			sync_fail_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Avalon-MM slave
	// ****************************************************************
	// Every access waits exactly one cycle, giving time to register read data
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
	assign wr_acc            = avs_write_i && ack_r;
	assign rd_acc            = avs_read_i && ack_r;
	assign avs_readdata_o    = rdata_r;
	assign status_view       = {5'h00, sync_fail_r, 1'b0, sync_active_r && sync_on};

	// Acknowledge pulses high for one cycle per request
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read_i || avs_write_i) && !ack_r;
		end
	end

	// Read data captured in the wait cycle; unmapped indices read zero
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (avs_read_i && !ack_r) begin
			if (hit(avs_address_i, IDX_PORT_DISABLE))
				rdata_r <= {24'h000000, port_dis_r};
			else if (hit(avs_address_i, IDX_MODE_CONTROL))
				rdata_r <= {24'h000000, mode_r};
			else if (hit(avs_address_i, IDX_STATUS))
				rdata_r <= {24'h000000, status_view};
			else if (hit(avs_address_i, IDX_IRQ_STATUS))
				rdata_r <= {30'h00000000, irq_sts_r};
			else if (hit(avs_address_i, IDX_IRQ_MASK))
				rdata_r <= {30'h00000000, irq_mask_r};
			else
				rdata_r <= 32'h0000_0000;
		end
	end

	// Control registers; writes clear reserved bits, but the mode reset value sets reserved bit 1
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			port_dis_r <= RST_PORT_DISABLE;
			mode_r     <= RST_MODE_CONTROL;
			irq_mask_r <= RST_IRQ;
		end else if (wr_acc && avs_byteenable_i[0]) begin
			if (hit(avs_address_i, IDX_PORT_DISABLE))
				port_dis_r <= avs_writedata_i[7:0] & DIS_WR_MASK;
			if (hit(avs_address_i, IDX_MODE_CONTROL))
				mode_r <= avs_writedata_i[7:0] & MODE_WR_MASK;
			if (hit(avs_address_i, IDX_IRQ_MASK))
				irq_mask_r <= avs_writedata_i[1:0];
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	// Write one to clear; a same-cycle event keeps its bit set
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_sts_r <= RST_IRQ;
		end else begin
			if (wr_acc && avs_byteenable_i[0] && hit(avs_address_i, IDX_IRQ_STATUS))
				irq_sts_r <= (irq_sts_r & ~avs_writedata_i[1:0]) | {gain_evt, fail_evt};
			else
				irq_sts_r <= irq_sts_r | {gain_evt, fail_evt};
		end
	end

	assign irq_o = |(irq_sts_r & irq_mask_r);

endmodule // csfwd_engine

// File: bench/csfwd_engine_assertions.sv
// Checker: bus, stream and register relations of the forwarding engine
`timescale 1ns/1ps
module csfwd_engine_assertions
	import csfwd_pkg::*;
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	// Register bus
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0]  avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	// Stream and interrupt
	input wire logic [3:0]  rx_ready_o,
	input wire logic        tx_valid_o,
	input wire csfwd_beat_s tx_beat_o,
	input wire logic        tx_ready_i,
	input wire logic        irq_o
);
	// ****************************************************************
	// Shadow state
	// ****************************************************************
	logic [7:0] dis_r;
	logic [7:0] mode_r;
	logic [1:0] mask_r;
	logic       seen_r;
	logic       pkt_r;
	logic [1:0] port_r;
	logic       wr_ok;
	logic       rd_ok;
	assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	assign rd_ok = avs_read_i && !avs_waitrequest_o;
	// Follow software writes; lane 0 carries every field
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dis_r <= RST_PORT_DISABLE;
			mode_r <= RST_MODE_CONTROL;
			mask_r <= 2'h0;
			seen_r <= 1'b0;
		end else if (wr_ok) begin
			if (avs_address_i == 8'h80) dis_r <= avs_writedata_i[7:0] & DIS_WR_MASK;
			if (avs_address_i == 8'h80) seen_r <= seen_r || (avs_writedata_i[7:4] != 4'hf);
			if (avs_address_i == 8'h84) mode_r <= avs_writedata_i[7:0] & MODE_WR_MASK;
			if (avs_address_i == 8'hc4) mask_r <= avs_writedata_i[1:0];
		end
	end
	// Packet currently open on the output
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pkt_r <= 1'b0;
			port_r <= 2'h0;
		end else if (tx_valid_o && tx_ready_i) begin
			pkt_r <= !tx_beat_o.eop;
			port_r <= tx_beat_o.port;
		end
	end
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence req_s;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence stall_s;
		tx_valid_o && !tx_ready_i;
	endsequence
	wait_one_a: assert property (req_s |=> !avs_waitrequest_o) else $error("bus answer late");
	wait_first_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o) else $error("no wait state");
	tx_hold_a: assert property (stall_s |=> tx_valid_o && $stable(tx_beat_o)) else $error("beat dropped under stall");
	reset_idle_a: assert property (!seen_r |-> !tx_valid_o && rx_ready_o == 4'hf) else $error("traffic while disabled");
	dis_read_a: assert property (rd_ok && avs_address_i == 8'h80 |-> avs_readdata_o == {24'h0, dis_r}) else $error("disable readback");
	mode_read_a: assert property (rd_ok && avs_address_i == 8'h84 |-> avs_readdata_o == {24'h0, mode_r}) else $error("mode readback");
	sync_off_a: assert property (rd_ok && avs_address_i == 8'h88 && mode_r[3:2] == 2'h0 |-> !avs_readdata_o[0]) else $error("sync bit set");
	unmapped_a: assert property (rd_ok && !(avs_address_i inside {8'h80, 8'h84, 8'h88, 8'hc0, 8'hc4}) |-> avs_readdata_o == 32'h0) else $error("unmapped read");
	irq_mask_a: assert property (irq_o |-> mask_r != 2'h0) else $error("irq while masked");
	pkt_whole_a: assert property (tx_valid_o && pkt_r |-> tx_beat_o.port == port_r) else $error("packets interleaved");
endmodule // csfwd_engine_assertions

// File: bench/csfwd_sink.sv
// Downstream CSI-2 receiver model: takes output beats with optional stalls
`timescale 1ns/1ps
module csfwd_sink (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	// Stall control and stream handshake
	input  wire logic slow_i,
	output logic      tx_ready_o
);
	logic [7:0] lfsr_r;
	// Pseudo-random back-pressure so held beats get exercised
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			lfsr_r <= 8'h5a;
		else
			lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
	end
	assign tx_ready_o = !slow_i || lfsr_r[0];
endmodule // csfwd_sink

// File: bench/testbench.sv
// Testbench: register, interrupt and forwarding scenarios for the engine
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	import csfwd_pkg::*;
	logic        clk_i, rst_b_i, avs_read_i, avs_write_i, tx_ready_i, slow_r, drop_r;
	logic        avs_waitrequest_o, tx_valid_o, irq_o;
	logic [7:0]  avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, seed_r;
	logic [3:0]  avs_byteenable_i, rx_valid_i, rx_ready_o;
	logic [63:0] reg_q [$];
	csfwd_beat_s rx_beat_i [NPORT];
	csfwd_beat_s tx_beat_o, got_b;
	csfwd_beat_s exp_q [NPORT][$];
	int          err_total, n_compared, tx_seen, snap;
	csfwd_engine csfwd_engine_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.rx_valid_i(rx_valid_i), .rx_beat_i(rx_beat_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
		.tx_beat_o(tx_beat_o), .tx_ready_i(tx_ready_i), .irq_o(irq_o));
	csfwd_sink csfwd_sink_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(slow_r), .tx_ready_o(tx_ready_i));
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		int i;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_read_i <= !w;
		avs_write_i <= w;
		avs_writedata_i <= {24'h0, d};
		for (i = 0; i < 50; i++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		if (i == 50) begin err_total++; conclude(); end
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		reg_q.push_back({24'h0, e, 24'hffffff, m});
		bus(a, 1'b0, 8'h0);
	endtask
	// Packet of n beats on port p; expectations noted unless dropped
	task automatic send(input int p, input int n, input logic lp, input logic fe);
		int i, k;
		csfwd_beat_s b;
		for (k = 0; k < n; k++) begin
			@(posedge clk_i);
			seed_r = xs(seed_r);
			b = '{data: seed_r, port: 2'(p), sop: k == 0, eop: k == n - 1, long_pkt: lp, frame_end: fe};
			rx_beat_i[p] <= b;
			rx_valid_i[p] <= 1'b1;
			if (!drop_r) exp_q[p].push_back(b);
			for (i = 0; i < 6000; i++) begin
				@(posedge clk_i);
				if (rx_ready_o[p] === 1'b1) break;
			end
			if (i == 6000) begin err_total++; conclude(); end
			rx_valid_i[p] <= 1'b0;
		end
	endtask
	task automatic drain();
		int i;
		for (i = 0; i < 300 && exp_q[0].size() + exp_q[1].size() != 0; i++) @(posedge clk_i);
		`CHK(exp_q[0].size() + exp_q[1].size(), 0)
	endtask
	// Port 0 packet (line or short) must wait for port 1 before anything leaves
	task automatic hold(input logic [7:0] md, input logic lp, input logic fe);
		bus(8'h84, 1'b1, md);
		fork
			send(0, 2, lp, fe);
			begin
				snap = tx_seen;
				repeat (30) @(posedge clk_i);
				`CHK(tx_seen, snap)
				send(1, 2, lp, fe);
			end
		join
		drain();
	endtask
	// ****************************************************************
	// Output monitor: oldest note against each result
	// ****************************************************************
	always @(posedge clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0 && reg_q.size() != 0) begin
			`CHK(avs_readdata_o & reg_q[0][31:0], reg_q[0][63:32])
			void'(reg_q.pop_front());
		end
		if (tx_valid_o === 1'b1 && tx_ready_i) begin
			tx_seen++;
			`CHK(exp_q[tx_beat_o.port].size() != 0, 1'b1)
			if (exp_q[tx_beat_o.port].size() != 0) begin
				got_b = exp_q[tx_beat_o.port].pop_front();
				`CHK(tx_beat_o, got_b)
			end
		end
	end
	// Free-running clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{rst_b_i, avs_read_i, avs_write_i, slow_r, drop_r, rx_valid_i} = '0;
		{avs_address_i, avs_writedata_i, err_total, n_compared, tx_seen} = '0;
		avs_byteenable_i = 4'hf;
		seed_r = 32'h5f;
		for (int p = 0; p < NPORT; p++) rx_beat_i[p] = '0;
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(8'h80, 8'hf0, 8'hff);
		rd(8'h84, RST_MODE_CONTROL, 8'hff);
		rd(8'h88, 8'h00, 8'hff);
		rd(8'h10, 8'h00, 8'hff);
		rd(8'hc4, 8'h00, 8'hff);
		drop_r = 1'b1;
		send(0, 2, 1'b1, 1'b0);
		repeat (10) @(posedge clk_i);
		`CHK(tx_seen, 0)
		drop_r = 1'b0;
		avs_byteenable_i <= 4'h0;
		bus(8'h80, 1'b1, 8'h00);
		avs_byteenable_i <= 4'hf;
		bus(8'h80, 1'b1, 8'hcf);
		rd(8'h80, 8'hc0, 8'hff);
		slow_r <= 1'b1;
		fork
			send(0, 3, 1'b1, 1'b0);
			send(1, 3, 1'b1, 1'b0);
		join
		drain();
		for (int m = 0; m < 4; m++) begin
			bus(8'h84, 1'b1, {4'h0, 2'(m), 2'h0});
			rd(8'h84, {4'h0, 2'(m), 2'h0}, 8'hff);
		end
		bus(8'h84, 1'b1, 8'hfe);
		rd(8'h84, 8'h4c, 8'hff);
		bus(8'h84, 1'b1, 8'h01);
		rd(8'h88, 8'h00, 8'h01);
		hold(8'h04, 1'b1, 1'b0);
		rd(8'h88, 8'h01, 8'h01);
		rd(8'hc0, 8'h02, 8'h02);
		bus(8'hc4, 1'b1, 8'h02);
		@(negedge clk_i);
		`CHK(irq_o, 1'b1)
		bus(8'hc0, 1'b1, 8'h02);
		@(negedge clk_i);
		`CHK(irq_o, 1'b0)
		hold(8'h08, 1'b1, 1'b0);
		hold(8'h44, 1'b0, 1'b0);
		hold(8'h4c, 1'b1, 1'b0);
		bus(8'h84, 1'b1, 8'h44);
		send(0, 2, 1'b1, 1'b0);
		drain();
		hold(8'h04, 1'b0, 1'b1);
		fork
			send(0, 1, 1'b1, 1'b0);
			begin
				repeat (4100) @(posedge clk_i);
				rd(8'h88, 8'h04, 8'h04);
				rd(8'h88, 8'h00, 8'h04);
				bus(8'h80, 1'b1, 8'he0);
			end
		join
		drain();
		rst_b_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		rd(8'h80, 8'hf0, 8'hff);
		conclude();
	end
endmodule // testbench
bind csfwd_engine csfwd_engine_assertions chk_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
	.tx_beat_o(tx_beat_o), .tx_ready_i(tx_ready_i), .irq_o(irq_o));
